// [rtl/ubrg_pkg.sv]
// constants, register map and state codes of the uart baud rate generator
// assumes one 125 MHz peripheral clock; the timer output comes from logic on that clock
// Behaviour
// - source field selects timer, clock/2, /8, /32
// - base clock held low while port power off
// - tx counter zero unless power and tx enable
// - tx counter counts once power and tx enable
// - first tx data write clears tx counter
// - rx counter zero unless power and rx enable
// - rx counter idle until falling edge start
// - rx counter stops after frame until start
// - five-bit counters clocked by chosen base clock
// - divisor k in bits 4:0, 8 to 31
// - bit period spans 2k base clocks
// - timer output feeds generator regardless pin enable
// - separate independent tx and rx counters
// - count k after edge, low confirms start
package ubrg_pkg;
    // register byte addresses on the plain port
    localparam logic [4:0] ADDR_BAUD = 5'h00; // baud control register
    localparam logic [4:0] ADDR_MODE = 5'h04; // serial mode register
    localparam logic [4:0] ADDR_STAT = 5'h08; // live status, read only
    localparam logic [4:0] ADDR_TXCNT = 5'h0C; // tx counter value, read only
    localparam logic [4:0] ADDR_RXCNT = 5'h10; // rx counter value, read only
    // baud control fields
    localparam int SRC_HI = 7; // clock source select msb
    localparam int SRC_LO = 6; // clock source select lsb
    localparam int DIV_HI = 4; // divisor select msb
    localparam int DIV_LO = 0; // divisor select lsb
    // serial mode fields
    localparam int PWR_BIT = 7; // port power bit
    localparam int TXE_BIT = 6; // tx enable bit
    localparam int RXE_BIT = 5; // rx enable bit
    // status fields
    localparam int ST_RUN = 7; // rx frame in progress
    localparam int ST_CHK = 6; // rx start bit being confirmed
    localparam int ST_TXS = 5; // tx serial clock level
    localparam int ST_RXS = 4; // rx serial clock level
    // reset values
    localparam logic [7:0] BAUD_RST = 8'h48; // clock/2, k = 8
    localparam logic [7:0] MODE_RST = 8'h00; // powered down
    localparam logic [7:0] ZERO8 = 8'h00;
    localparam logic [4:0] ZERO5 = 5'h00;
    localparam logic [4:0] ONE5 = 5'h01;
    // clock source codes
    localparam logic [1:0] SRC_TIMER = 2'h0; // timer channel output
    localparam logic [1:0] SRC_DIV2 = 2'h1; // peripheral clock / 2
    localparam logic [1:0] SRC_DIV8 = 2'h2; // peripheral clock / 8
    localparam logic [1:0] SRC_DIV32 = 2'h3; // peripheral clock / 32
    // prescaler masks: all masked bits set marks the divided tick
    localparam logic [4:0] PRE_MASK2 = 5'h01;
    localparam logic [4:0] PRE_MASK8 = 5'h07;
    localparam logic [4:0] PRE_MASK32 = 5'h1F;
    localparam logic [4:0] K_MIN = 5'h08; // smallest legal divisor
    // receive counter states
    typedef enum logic [2:0] {
        UBRG_RX_IDLE = 3'b001,
        UBRG_RX_CHECK = 3'b010,
        UBRG_RX_RUN = 3'b100
    } ubrg_rx_state_t;
endpackage

// [rtl/ubrg_top.sv]
// baud rate generator: base clock selector, tx and rx five-bit bit-clock counters
// assumes the register master and the shifters run on ref_clk_i; the serial pin is async
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ps
module ubrg_top (
    input wire logic ref_clk_i, // 125 MHz peripheral clock
    input wire logic rst_i, // synchronous, active high
    input wire logic [4:0] addr_i, // register byte address
    input wire logic [7:0] wdata_i, // register write data
    input wire logic wr_i, // write strobe
    input wire logic rd_i, // read strobe
    input wire logic tx_load_i, // tx shift register written
    input wire logic rx_frame_done_i, // rx shifter took the stop bit
    input wire logic timer_channel_output_i, // timer output, same clock
    input wire logic serial_input_pin_i, // rx pin, asynchronous
    output logic [7:0] rdata_o, // read data, cycle after rd_i
    output logic base_tick_o, // one base clock pulse
    output logic tx_sclk_o, // tx bit clock
    output logic rx_sclk_o, // rx bit clock
    output logic rx_start_o // start bit confirmed pulse
);
    import ubrg_pkg::*;

    // terminal count for divisor k; a divisor below the legal range is a software fault
    function automatic logic at_end(input logic [4:0] cnt, input logic [4:0] k);
        at_end = (cnt >= (k - ONE5));
    endfunction

    logic [7:0] baud_q, baud_d; // baud control register
    logic [7:0] mode_q, mode_d; // serial mode register
    logic [7:0] rdata_q, rdata_d; // read data holder
    logic [4:0] pre_q, pre_d; // free prescaler
    logic tmr_q, tmr_d; // last timer output level
    logic base_q, base_d; // registered base tick
    logic sync1_q, sync2_q, sync3_q; // pin synchroniser and edge history
    logic [4:0] tx_cnt_q, tx_cnt_d; // tx counter
    logic tx_sclk_q, tx_sclk_d; // tx bit clock
    logic tx_first_q, tx_first_d; // next load is the first word
    logic [4:0] rx_cnt_q, rx_cnt_d; // rx counter
    logic rx_sclk_q, rx_sclk_d; // rx bit clock
    logic rx_start_q, rx_start_d; // start confirmed pulse
    ubrg_rx_state_t rx_st_q, rx_st_d; // rx counter state
    logic [1:0] src; // chosen clock source
    logic [4:0] k; // divisor
    logic pwr, tx_en, rx_en; // gating levels
    logic fall; // falling edge on synced pin

    assign src = baud_q[SRC_HI:SRC_LO];
    assign k = baud_q[DIV_HI:DIV_LO];
    assign pwr = mode_q[PWR_BIT];
    assign tx_en = pwr & mode_q[TXE_BIT];
    assign rx_en = pwr & mode_q[RXE_BIT];
    // edge looks at second and third stages only, never the first
    assign fall = sync3_q & ~sync2_q;

    // register writes and reads
    always_comb begin
        baud_d = baud_q;
        mode_d = mode_q;
        rdata_d = ZERO8; // unmapped and idle reads give zero
        if (wr_i) begin
            if (addr_i == ADDR_BAUD) begin
                baud_d = wdata_i;
            end else if (addr_i == ADDR_MODE) begin
                mode_d = wdata_i;
            end
        end
        if (rd_i) begin
            if (addr_i == ADDR_BAUD) begin
                rdata_d = baud_q;
            end else if (addr_i == ADDR_MODE) begin
                rdata_d = mode_q;
            end else if (addr_i == ADDR_STAT) begin
                rdata_d = ZERO8;
                rdata_d[ST_RUN] = (rx_st_q == UBRG_RX_RUN);
                rdata_d[ST_CHK] = (rx_st_q == UBRG_RX_CHECK);
                rdata_d[ST_TXS] = tx_sclk_q;
                rdata_d[ST_RXS] = rx_sclk_q;
            end else if (addr_i == ADDR_TXCNT) begin
                rdata_d = {3'h0, tx_cnt_q};
            end else if (addr_i == ADDR_RXCNT) begin
                rdata_d = {3'h0, rx_cnt_q};
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            baud_q <= BAUD_RST;
            mode_q <= MODE_RST;
            rdata_q <= ZERO8;
        end else begin
            baud_q <= baud_d;
            mode_q <= mode_d;
            rdata_q <= rdata_d;
        end
    end

    // base clock selection; the timer output is taken internally, so the
    // timer's pin enable has no say here
    always_comb begin
        pre_d = pre_q + ONE5;
        tmr_d = timer_channel_output_i;
        base_d = 1'b0;
        if (src == SRC_TIMER) begin
            base_d = timer_channel_output_i & ~tmr_q;
        end else if (src == SRC_DIV2) begin
            base_d = ((pre_q & PRE_MASK2) == PRE_MASK2);
        end else if (src == SRC_DIV8) begin
            base_d = ((pre_q & PRE_MASK8) == PRE_MASK8);
        end else begin
            base_d = ((pre_q & PRE_MASK32) == PRE_MASK32);
        end
        if (!pwr) begin
            base_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pre_q <= ZERO5;
            tmr_q <= 1'b0;
            base_q <= 1'b0;
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            sync3_q <= 1'b1;
        end else begin
            pre_q <= pre_d;
            tmr_q <= tmr_d;
            base_q <= base_d;
            sync1_q <= serial_input_pin_i;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // tx counter: its own five bits, so tx timing never waits on rx
    always_comb begin
        tx_cnt_d = tx_cnt_q;
        tx_sclk_d = tx_sclk_q;
        tx_first_d = tx_first_q;
        if (!tx_en) begin
            tx_cnt_d = ZERO5;
            tx_sclk_d = 1'b0;
            tx_first_d = 1'b1;
        end else if (tx_load_i && tx_first_q) begin
            tx_cnt_d = ZERO5;
            tx_sclk_d = 1'b0;
            tx_first_d = 1'b0;
        end else if (base_q) begin
            // toggle every k ticks gives a 2k-tick bit period
            if (at_end(tx_cnt_q, k)) begin
                tx_cnt_d = ZERO5;
                tx_sclk_d = ~tx_sclk_q;
            end else begin
                tx_cnt_d = tx_cnt_q + ONE5;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            tx_cnt_q <= ZERO5;
            tx_sclk_q <= 1'b0;
            tx_first_q <= 1'b1;
        end else begin
            tx_cnt_q <= tx_cnt_d;
            tx_sclk_q <= tx_sclk_d;
            tx_first_q <= tx_first_d;
        end
    end

    // rx counter: idle, confirm start after k ticks, then run for one frame
    always_comb begin
        rx_cnt_d = rx_cnt_q;
        rx_sclk_d = rx_sclk_q;
        rx_st_d = rx_st_q;
        rx_start_d = 1'b0;
        if (!rx_en) begin
            rx_cnt_d = ZERO5;
            rx_sclk_d = 1'b0;
            rx_st_d = UBRG_RX_IDLE;
        end else begin
            case (rx_st_q)
                UBRG_RX_IDLE: begin
                    rx_cnt_d = ZERO5;
                    rx_sclk_d = 1'b0;
                    if (fall) begin
                        rx_st_d = UBRG_RX_CHECK;
                    end
                end
                UBRG_RX_CHECK: begin
                    if (base_q) begin
                        if (at_end(rx_cnt_q, k)) begin
                            rx_cnt_d = ZERO5;
                            // a glitch shorter than k ticks is dropped here
                            if (!sync2_q) begin
                                rx_st_d = UBRG_RX_RUN;
                                rx_start_d = 1'b1;
                            end else begin
                                rx_st_d = UBRG_RX_IDLE;
                            end
                        end else begin
                            rx_cnt_d = rx_cnt_q + ONE5;
                        end
                    end
                end
                UBRG_RX_RUN: begin
                    if (rx_frame_done_i) begin
                        rx_st_d = UBRG_RX_IDLE;
                        rx_cnt_d = ZERO5;
                        rx_sclk_d = 1'b0;
                    end else if (base_q) begin
                        if (at_end(rx_cnt_q, k)) begin
                            rx_cnt_d = ZERO5;
                            rx_sclk_d = ~rx_sclk_q;
                        end else begin
                            rx_cnt_d = rx_cnt_q + ONE5;
                        end
                    end
                end
                default: begin
                    rx_st_d = UBRG_RX_IDLE;
                    rx_cnt_d = ZERO5;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rx_cnt_q <= ZERO5;
            rx_sclk_q <= 1'b0;
            rx_st_q <= UBRG_RX_IDLE;
            rx_start_q <= 1'b0;
        end else begin
            rx_cnt_q <= rx_cnt_d;
            rx_sclk_q <= rx_sclk_d;
            rx_st_q <= rx_st_d;
            rx_start_q <= rx_start_d;
        end
    end

    assign rdata_o = rdata_q;
    assign base_tick_o = base_q;
    assign tx_sclk_o = tx_sclk_q;
    assign rx_sclk_o = rx_sclk_q;
    assign rx_start_o = rx_start_q;

    // checks beside the logic they guard
    property p_div2_tick;
        @(posedge ref_clk_i) disable iff (rst_i)
        (pwr && src == SRC_DIV2 && pre_q[0] && !wr_i) |=> base_q;
    endproperty
    a_div2_tick: assert property (p_div2_tick) else $error("div2 tick missing");

    property p_power_gate;
        @(posedge ref_clk_i) disable iff (rst_i)
        (!pwr && !wr_i) [*2] |=> !base_q;
    endproperty
    a_power_gate: assert property (p_power_gate) else $error("base tick while off");

    property p_tx_halt;
        @(posedge ref_clk_i) disable iff (rst_i)
        !tx_en |=> (tx_cnt_q == ZERO5) && !tx_sclk_q;
    endproperty
    a_tx_halt: assert property (p_tx_halt) else $error("tx counter not held");

    property p_tx_count;
        @(posedge ref_clk_i) disable iff (rst_i)
        (tx_en && base_q && !at_end(tx_cnt_q, k) && !(tx_load_i && tx_first_q))
            |=> tx_cnt_q == $past(tx_cnt_q) + ONE5;
    endproperty
    a_tx_count: assert property (p_tx_count) else $error("tx counter stalled");

    property p_tx_load;
        @(posedge ref_clk_i) disable iff (rst_i)
        (tx_en && tx_load_i && tx_first_q) |=> (tx_cnt_q == ZERO5) && !tx_first_q;
    endproperty
    a_tx_load: assert property (p_tx_load) else $error("tx load did not clear");

    property p_tx_toggle;
        @(posedge ref_clk_i) disable iff (rst_i)
        (tx_en && base_q && at_end(tx_cnt_q, k) && !(tx_load_i && tx_first_q))
            |=> (tx_sclk_q != $past(tx_sclk_q)) && (tx_cnt_q == ZERO5);
    endproperty
    a_tx_toggle: assert property (p_tx_toggle) else $error("tx sclk no toggle");

    property p_rx_halt;
        @(posedge ref_clk_i) disable iff (rst_i)
        !rx_en |=> (rx_cnt_q == ZERO5) && (rx_st_q == UBRG_RX_IDLE);
    endproperty
    a_rx_halt: assert property (p_rx_halt) else $error("rx counter not held");

    property p_rx_idle;
        @(posedge ref_clk_i) disable iff (rst_i)
        (rx_st_q == UBRG_RX_IDLE && !fall) |=> (rx_st_q == UBRG_RX_IDLE) && (rx_cnt_q == ZERO5);
    endproperty
    a_rx_idle: assert property (p_rx_idle) else $error("rx left idle early");

    property p_rx_stop;
        @(posedge ref_clk_i) disable iff (rst_i)
        (rx_st_q == UBRG_RX_RUN && rx_frame_done_i) |=> (rx_st_q == UBRG_RX_IDLE) && !rx_sclk_q;
    endproperty
    a_rx_stop: assert property (p_rx_stop) else $error("rx ran past frame");

    property p_rx_start;
        @(posedge ref_clk_i) disable iff (rst_i)
        (rx_en && rx_st_q == UBRG_RX_CHECK && base_q && at_end(rx_cnt_q, k) && !sync2_q)
            |=> rx_start_q && (rx_st_q == UBRG_RX_RUN) ##1 !rx_start_q;
    endproperty
    a_rx_start: assert property (p_rx_start) else $error("start not confirmed");

endmodule // ubrg_top

// [dv/ubrg_partner.sv]
// model of the uart shifters and the 8-bit timer that sit around the baud generator
// assumes one clock for everything; the testbench asks for tx loads
`timescale 1ns/1ps
module ubrg_partner (
    input wire logic clk_i, // peripheral clock
    input wire logic rst_i, // synchronous, active high
    input wire logic timer_run_i, // timer started by software
    input wire logic load_req_i, // software writes tx data
    input wire logic rx_start_i, // start bit confirmed
    input wire logic rx_sclk_i, // rx bit clock
    output logic timer_o, // timer channel output
    output logic tx_load_o, // tx shift register written
    output logic frame_done_o // stop bit taken
);
    logic [2:0] tdiv_q; // timer half period count
    logic [1:0] edges_q; // rx bit clock edges seen
    logic busy_q; // rx frame in progress
    logic sclk_q; // last rx bit clock
    // timer toggles every five cycles, 50% duty, only once it has been started
    always_ff @(posedge clk_i) begin
        if (rst_i || !timer_run_i) begin
            tdiv_q <= 3'h0;
            timer_o <= 1'b0;
        end else if (tdiv_q == 3'h4) begin
            tdiv_q <= 3'h0;
            timer_o <= ~timer_o;
        end else begin
            tdiv_q <= tdiv_q + 3'h1;
        end
    end
    // tx load is registered: one cycle after the request
    always_ff @(posedge clk_i) begin
        tx_load_o <= load_req_i && !rst_i;
    end
    // short frame of two bits keeps runs brief: four bit clock edges, then stop
    always_ff @(posedge clk_i) begin
        sclk_q <= rx_sclk_i;
        frame_done_o <= 1'b0;
        if (rst_i) begin
            busy_q <= 1'b0;
            edges_q <= 2'h0;
        end else if (rx_start_i) begin
            busy_q <= 1'b1;
            edges_q <= 2'h0;
        end else if (busy_q && (rx_sclk_i != sclk_q)) begin
            edges_q <= edges_q + 2'h1;
            if (edges_q == 2'h3) begin
                busy_q <= 1'b0;
                frame_done_o <= 1'b1;
            end
        end
    end
endmodule // ubrg_partner

// [dv/tb_top.sv]
// self-checking bench for the baud rate generator with the shifter model beside it
// assumes the register map and timing of ubrg_pkg; 125 MHz clock
`timescale 1ns/1ps
module tb_top;
    import ubrg_pkg::*;
    logic ref_clk_i, rst_i, wr_i, rd_i, pin, t_run, ld_req; // bench driven
    logic [4:0] addr_i; // register address
    logic [7:0] wdata_i, rdata_o, rd_v; // bus data, last read
    logic tick, tx_sclk, rx_sclk, rx_start, tmr, tx_ld, fdone; // dut and model
    int n_mismatch, n_compared, n_start, cyc, n; // counters
    ubrg_top dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .tx_load_i(tx_ld), .rx_frame_done_i(fdone),
        .timer_channel_output_i(tmr), .serial_input_pin_i(pin), .rdata_o(rdata_o),
        .base_tick_o(tick), .tx_sclk_o(tx_sclk), .rx_sclk_o(rx_sclk), .rx_start_o(rx_start));
    ubrg_partner prt (.clk_i(ref_clk_i), .rst_i(rst_i), .timer_run_i(t_run),
        .load_req_i(ld_req), .rx_start_i(rx_start), .rx_sclk_i(rx_sclk), .timer_o(tmr),
        .tx_load_o(tx_ld), .frame_done_o(fdone));
    // clock, 8 ns period
    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end
    // start pulses counted mid-cycle, clear of the edge that launches them
    always @(negedge ref_clk_i) begin
        if (rx_start === 1'b1) begin
            n_start <= n_start + 1;
        end
    end
    // timeout well above the few thousand cycles the tests need
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 50000) begin
            n_mismatch = n_mismatch + 1;
            final_report();
        end
    end
    task automatic final_report();
        $display("counts: %0d compared, %0d mismatched", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    // one-cycle strobes, changed right after the edge
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [4:0] a);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1 rd_v = rdata_o;
    endtask
    function automatic logic sig(input int s);
        return (s == 0) ? tick : (s == 1) ? tx_sclk : rx_sclk;
    endfunction
    // cycles to next tick (s 0) or toggle (s 1, 2); 400 means none seen
    task automatic nxt(input int s, output int c);
        logic p;
        #1 p = sig(s);
        for (c = 1; c < 400; c++) begin
            @(posedge ref_clk_i);
            #1;
            if (s == 0 ? sig(s) === 1'b1 : sig(s) !== p) break;
        end
    endtask
    task automatic gap(input int s, output int c);
        int m;
        nxt(s, m);
        nxt(s, c);
    endtask
    task automatic pin_low(input int c);
        @(posedge ref_clk_i);
        pin <= 1'b0;
        repeat (c) @(posedge ref_clk_i);
        pin <= 1'b1;
    endtask
    task automatic t_regs();
        rd(ADDR_BAUD);
        chk(rd_v, 8'h48);
        rd(ADDR_MODE);
        chk(rd_v, 8'h00);
        wr(ADDR_BAUD, 8'h5F);
        rd(ADDR_BAUD);
        chk(rd_v, 8'h5F);
        rd(5'h1C);
        chk(rd_v, 8'h00);
        nxt(0, n);
        chk(n, 400);
        $display("test regs done");
    endtask
    task automatic t_source();
        wr(ADDR_MODE, 8'h80);
        wr(ADDR_BAUD, 8'h48);
        gap(0, n);
        chk(n, 2);
        wr(ADDR_BAUD, 8'h88);
        gap(0, n);
        chk(n, 8);
        wr(ADDR_BAUD, 8'hC8);
        gap(0, n);
        chk(n, 32);
        // timer is started before it is chosen as the base clock
        @(posedge ref_clk_i);
        t_run <= 1'b1;
        wr(ADDR_BAUD, 8'h08);
        gap(0, n);
        chk(n, 10);
        wr(ADDR_MODE, 8'h00);
        nxt(0, n);
        chk(n, 400);
        $display("test source done");
    endtask
    task automatic t_tx();
        wr(ADDR_BAUD, 8'h48);
        wr(ADDR_MODE, 8'hE0);
        repeat (7) @(posedge ref_clk_i);
        ld_req <= 1'b1;
        @(posedge ref_clk_i);
        ld_req <= 1'b0;
        rd(ADDR_TXCNT);
        chk(rd_v <= 8'h01, 1);
        gap(1, n);
        chk(n, 16);
        chk(rx_sclk, 1'b0);
        wr(ADDR_BAUD, 8'h5F);
        gap(1, n);
        chk(n, 62);
        wr(ADDR_MODE, 8'hA0);
        repeat (2) @(posedge ref_clk_i);
        #1 chk(tx_sclk, 1'b0);
        rd(ADDR_TXCNT);
        chk(rd_v, 8'h00);
        $display("test tx done");
    endtask
    task automatic t_rx();
        wr(ADDR_BAUD, 8'h48);
        wr(ADDR_MODE, 8'h80);
        pin_low(100);
        chk(n_start, 0);
        wr(ADDR_MODE, 8'hA0);
        pin_low(4);
        // glitch still under confirmation: only the check flag is up
        rd(ADDR_STAT);
        chk(rd_v, 8'h40);
        repeat (40) @(posedge ref_clk_i);
        chk(n_start, 0);
        fork
            pin_low(120);
            gap(2, n);
        join
        chk(n, 16);
        chk(n_start, 1);
        nxt(2, n);
        chk(n, 400);
        rd(ADDR_RXCNT);
        chk(rd_v, 8'h00);
        wr(ADDR_MODE, 8'h00);
        rd(ADDR_RXCNT);
        chk(rd_v, 8'h00);
        $display("test rx done");
    endtask
    // reset for 20 cycles, then the tests in order
    initial begin
        {rst_i, wr_i, rd_i, t_run, ld_req} = 5'b10000;
        {addr_i, wdata_i} = 13'h0000;
        pin = 1'b1;
        {n_mismatch, n_compared, n_start, cyc} = '0;
        repeat (20) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_source();
        t_tx();
        t_rx();
        final_report();
    end
endmodule // tb_top
